// ---- pkg/sersb_pkg.sv ----
// package: register map, field codes and timing for the sideband block
`default_nettype none
package sersb_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] LOW_FREQ_MODE_CONFIG_OFF     = 8'h04;
    localparam logic [7:0] LINK_DETECT_STATE_OFF        = 8'h0c;
    localparam logic [7:0] IO0_DIRECTION_CONFIG_OFF     = 8'h0d;
    localparam logic [7:0] IO1_IO2_DIRECTION_CONFIG_OFF = 8'h0e;
    localparam logic [7:0] IO3_OUT4_CONFIG_OFF          = 8'h0f;
    localparam logic [7:0] OUT5_OUT6_CONFIG_OFF         = 8'h10;
    localparam logic [7:0] OUT7_OUT8_CONFIG_OFF         = 8'h11;
    localparam logic [7:0] COLOUR_DEPTH_CONFIG_OFF      = 8'h12;
    localparam logic [7:0] INTERRUPT_FORWARD_CTRL_OFF   = 8'hc6;
    localparam logic [7:0] PROTECTION_IRQ_STATUS_OFF    = 8'hc7;
    localparam logic [7:0] SLEEP_CTRL_OFF               = 8'h05;
    // ==========================================================
    // field positions and codes
    localparam int         LATCH_EDGE_BIT      = 2;
    localparam int         SLEEP_EN_BIT        = 0;
    localparam int         FWD_EN_HI_BIT       = 5;
    localparam int         FWD_EN_LO_BIT       = 0;
    localparam logic [7:0] MODE_18BIT_CODE     = 8'h04;
    localparam logic [3:0] IO_INPUT_CODE       = 4'h3;
    localparam logic [3:0] IO_OUTPUT_CODE      = 4'h5;
    localparam logic [3:0] OUT_HIGH_CODE       = 4'h9;
    localparam logic [3:0] OUT_LOW_CODE        = 4'h1;
    // ==========================================================
    // reset values
    localparam logic [7:0] CFG_RESET           = 8'h00;
    localparam logic [7:0] LOW_FREQ_RESET      = 8'h04;
    // ==========================================================
    // timing: clock-loss threshold 1 MHz -> 1000 ns longest gap
    localparam int         SYS_PERIOD_NS       = 10;
    localparam int         CLK_LOSS_NS         = 1000;
    localparam int         CLK_LOSS_CYCLES     = CLK_LOSS_NS / SYS_PERIOD_NS;
    localparam int         BC_RATE_MBPS        = 10;
    localparam int         BC_BIT_CYCLES       =
        (1000 / BC_RATE_MBPS) / SYS_PERIOD_NS;
    localparam int         GPIO_COUNT          = 4;
    localparam int         OUT_COUNT           = 5;

    typedef enum logic [1:0] {
        SERSB_RUN,
        SERSB_SLEEP,
        SERSB_RELOCK
    } sersb_power_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sersb_bus_type;
endpackage : sersb_pkg
`default_nettype wire

// ---- hdl/sersb_top.sv ----
// sideband control: clock loss, link status, irq forward, gpio, outputs
`default_nettype none
// Operation
// RULE1: enabled sleep when pixel clock stops
// RULE2: wake and relock when clock returns
// RULE3: registers kept through clock loss
// RULE4: link status reads zero on fault
// RULE5: edge select: one rising, zero falling
// RULE6: low frequency range from register or pin
// RULE7: host resets after range change
// RULE8: host sets both forward enable bits
// RULE9: remote low drives irq output low
// RULE10: status read clears pending irq
// RULE11: new irq on next remote fall
// RULE12: 18-bit mode frees four io pins
// RULE13: code low_freq_mode_config enables 18-bit mode; the code decodes depth_cfg at COLOUR_DEPTH_CONFIG_OFF, code 8'h04, instead
// RULE14: io direction nibbles, three input five output
// RULE15: partner programs opposite io direction
// RULE16: register outputs driven only locally
// RULE17: output nibble nine high, one low
// RULE18: back channel carries four io bits
// RULE19: link status read only, live
module sersb_top
    import sersb_pkg::*;
#(
    parameter int LOSS_CYCLES = CLK_LOSS_CYCLES,
    parameter int BIT_CYCLES  = BC_BIT_CYCLES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  power_down_n,
    input  wire sersb_bus_type         bus,
    output logic [7:0]                 rdata,
    output logic                       rvalid,
    input  wire logic                  pclk_in,
    input  wire logic                  cable_fault,
    input  wire logic                  low_freq_range_select,
    input  wire logic                  remote_irq_in_n,
    input  wire logic [GPIO_COUNT-1:0] colour_low_in,
    input  wire logic [GPIO_COUNT-1:0] bc_gpio_in,
    output logic [GPIO_COUNT-1:0]      fc_gpio_out,
    output logic [GPIO_COUNT-1:0]      gpio_out,
    output logic [GPIO_COUNT-1:0]      gpio_oe_n,
    output logic [OUT_COUNT-1:0]       reg_driven_output,
    output logic                       latch_edge_rising,
    output logic                       low_freq_active,
    output logic                       mode_18bit,
    output logic                       sleep_active,
    output logic                       irq_out_n
);
    // ==========================================================
    // state
    // every flip-flop of the block but the pdn_sync pair sits in this one struct:
    // configuration bytes, read port, input synchronisers,
    // edge detectors, the gap counter, the power state and
    // the back-channel and forward io holding registers.
    // config fields survive clock loss; only reset clears them
    // the two irq sync stages and the delayed copy reset
    // high, the idle level of the remote pin, so that no
    // false fall follows reset
    typedef struct packed {
        logic [7:0]            lf_cfg;
        logic [7:0]            sleep_cfg;
        logic [7:0]            io0_cfg;
        logic [7:0]            io12_cfg;
        logic [7:0]            io3_cfg;
        logic [7:0]            o56_cfg;
        logic [7:0]            o78_cfg;
        logic [7:0]            depth_cfg;
        logic [7:0]            fwd_cfg;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [1:0]            pclk_s;
        logic                  pclk_d;
        logic [1:0]            fault_s;
        logic [1:0]            pin_lf_s;
        logic [1:0]            rirq_s;
        logic                  rirq_d;
        logic                  irq_pend;
        logic [15:0]           gap_cnt;
        logic                  clk_lost;
        sersb_power_type       pwr;
        logic [7:0]            bc_cnt;
        logic [GPIO_COUNT-1:0] bc_s1;
        logic [GPIO_COUNT-1:0] bc_s2;
        logic [GPIO_COUNT-1:0] bc_hold;
        logic [GPIO_COUNT-1:0] fc_s1;
        logic [GPIO_COUNT-1:0] fc_s2;
        logic [GPIO_COUNT-1:0] fc_hold;
    } sersb_state_type;

    sersb_state_type st_reg;
    sersb_state_type st_next;

    // power-down pin after two flip-flops, and the reset
    // that it forms together with rst
    logic [1:0]            pdn_sync;
    logic                  blk_rst;
    logic [3:0] io_nib [GPIO_COUNT];
    logic [3:0] out_nib [OUT_COUNT];
    logic [GPIO_COUNT-1:0] is_in;
    logic [GPIO_COUNT-1:0] is_out;
    logic [OUT_COUNT-1:0]  out_lvl;
    logic [OUT_COUNT-1:0]  out_ok;
    logic                  link_up;
    logic                  pclk_edge;
    logic                  fwd_en;
    logic                  rirq_fall;

    // ==========================================================
    // nibble selection per io and output
    // each io owns one direction nibble and each register
    // output one level nibble; io0 sits alone in its byte,
    // io1 and io2 share a byte, io3 shares with output 4,
    // outputs 5 to 8 fill the next two bytes, low nibble first
    assign io_nib[0]  = st_reg.io0_cfg[3:0];
    assign io_nib[1]  = st_reg.io12_cfg[3:0];
    assign io_nib[2]  = st_reg.io12_cfg[7:4];
    assign io_nib[3]  = st_reg.io3_cfg[3:0];
    assign out_nib[0] = st_reg.io3_cfg[7:4];
    assign out_nib[1] = st_reg.o56_cfg[3:0];
    assign out_nib[2] = st_reg.o56_cfg[7:4];
    assign out_nib[3] = st_reg.o78_cfg[3:0];
    assign out_nib[4] = st_reg.o78_cfg[7:4];

    // direction decode per io
    // a nibble counts only in 18-bit mode and only with one
    // of the two legal codes; anything else leaves the io
    // released with its enable high
    // an io set as input never drives, an io set as output
    // never feeds the forward channel
    genvar gi;
    generate
        for (gi = 0; gi < GPIO_COUNT; gi++) begin : g_io
            assign is_in[gi]  = mode_18bit
                && (io_nib[gi] == IO_INPUT_CODE);    // [RULE12] [RULE14]
            assign is_out[gi] = mode_18bit
                && (io_nib[gi] == IO_OUTPUT_CODE);   // [RULE14]
        end
    endgenerate

    // level decode per register output
    // codes other than the high and low codes drive a zero,
    // and nothing drives until 18-bit mode is on
    // levels come from local bytes only, never from the
    // serial link
    genvar go;
    generate
        for (go = 0; go < OUT_COUNT; go++) begin : g_out
            assign out_ok[go]  = mode_18bit
                && (out_nib[go] == OUT_HIGH_CODE
                || out_nib[go] == OUT_LOW_CODE);
            assign out_lvl[go] = out_ok[go]
                && (out_nib[go] == OUT_HIGH_CODE);   // [RULE16] [RULE17]
        end
    endgenerate

    // derived controls
    // the link bit follows the synchronised fault level;
    // the edge detectors compare the second sync stage with
    // a delayed copy so that no half-settled level is read
    // forwarding needs both enable bits at once
    // a remote fall is a high delayed copy beside a low
    // second stage
    assign mode_18bit  = (st_reg.depth_cfg == MODE_18BIT_CODE); // [RULE13]
    assign link_up     = ~st_reg.fault_s[1];             // [RULE4]
    assign pclk_edge   = st_reg.pclk_s[1] ^ st_reg.pclk_d;
    assign fwd_en      = st_reg.fwd_cfg[FWD_EN_HI_BIT]
                       & st_reg.fwd_cfg[FWD_EN_LO_BIT];  // [RULE8]
    assign rirq_fall   = st_reg.rirq_d & ~st_reg.rirq_s[1]; // [RULE11]

    // ==========================================================
    // next-state logic
    // defaults: hold every field, shift the synchronisers
    // and drop the read strobe; the sections below then
    // override only the fields that they own, in order,
    // so the later irq section has the last word
    // every path assigns through the copy, so the process
    // never leaves a field without a value
    always_comb begin
        st_next = st_reg;
        st_next.rvalid   = 1'b0;
        st_next.pclk_s   = {st_reg.pclk_s[0], pclk_in};
        st_next.pclk_d   = st_reg.pclk_s[1];
        st_next.fault_s  = {st_reg.fault_s[0], cable_fault};
        st_next.pin_lf_s = {st_reg.pin_lf_s[0], low_freq_range_select};
        st_next.rirq_s   = {st_reg.rirq_s[0], remote_irq_in_n};
        st_next.rirq_d   = st_reg.rirq_s[1];
        st_next.bc_s1    = bc_gpio_in;
        st_next.bc_s2    = st_reg.bc_s1;
        st_next.fc_s1    = colour_low_in;
        st_next.fc_s2    = st_reg.fc_s1;

        // pixel clock gap counter
        // counts cycles without a pixel clock edge and stops at
        // the limit; any edge restarts it, so a slow but live
        // clock never reaches the loss flag
        if (pclk_edge) begin
            st_next.gap_cnt  = 16'h0000;
            st_next.clk_lost = 1'b0;
        end else if (st_reg.gap_cnt >= 16'(LOSS_CYCLES - 1)) begin
            st_next.clk_lost = 1'b1;                     // [RULE1]
        end else begin
            st_next.gap_cnt = st_reg.gap_cnt + 16'h0001;
        end

        // power state; registers untouched here [RULE3]
        // sleep only when enabled; the first edge seen while
        // asleep starts the relock, which falls back to sleep
        // if the clock dies again before the flag clears
        // config bytes are never written from this section,
        // so clock loss leaves them as programmed
        case (st_reg.pwr)
            SERSB_RUN: begin
                if (st_reg.clk_lost && st_reg.sleep_cfg[SLEEP_EN_BIT])
                    st_next.pwr = SERSB_SLEEP;           // [RULE1]
            end
            SERSB_SLEEP: begin
                if (pclk_edge)
                    st_next.pwr = SERSB_RELOCK;          // [RULE2]
            end
            SERSB_RELOCK: begin
                if (!st_reg.clk_lost)
                    st_next.pwr = SERSB_RUN;             // [RULE2]
                else
                    st_next.pwr = SERSB_SLEEP;
            end
            default: st_next.pwr = SERSB_RUN;
        endcase

        // back channel sampling at line-rate bit slots
        // both io directions are taken at the same slot so the
        // held values change at the line rate and not faster
        // forward inputs are masked by the input config, so an
        // io set as output reads zero here
        if (st_reg.bc_cnt >= 8'(BIT_CYCLES - 1)) begin
            st_next.bc_cnt  = 8'h00;
            st_next.bc_hold = st_reg.bc_s2;              // [RULE18]
            st_next.fc_hold = st_reg.fc_s2 & is_in;      // [RULE12]
        end else begin
            st_next.bc_cnt = st_reg.bc_cnt + 8'h01;
        end

        // register writes
        // the link status and irq status offsets are absent
        // here, so writes to them and to unmapped offsets are
        // dropped without a trace
        // a write lands at the edge that samples the strobe
        if (bus.wr) begin
            case (bus.addr)
                LOW_FREQ_MODE_CONFIG_OFF:     st_next.lf_cfg    = bus.wdata;
                SLEEP_CTRL_OFF:               st_next.sleep_cfg = bus.wdata;
                IO0_DIRECTION_CONFIG_OFF:     st_next.io0_cfg   = bus.wdata;
                IO1_IO2_DIRECTION_CONFIG_OFF: st_next.io12_cfg  = bus.wdata;
                IO3_OUT4_CONFIG_OFF:          st_next.io3_cfg   = bus.wdata;
                OUT5_OUT6_CONFIG_OFF:         st_next.o56_cfg   = bus.wdata;
                OUT7_OUT8_CONFIG_OFF:         st_next.o78_cfg   = bus.wdata;
                COLOUR_DEPTH_CONFIG_OFF:      st_next.depth_cfg = bus.wdata;
                INTERRUPT_FORWARD_CTRL_OFF:   st_next.fwd_cfg   = bus.wdata;
                default: ;                               // [RULE19]
            endcase
        end

        // register reads
        // the answer lands one cycle after the strobe;
        // unmapped offsets read as zero
        // read data holds until the next read
        if (bus.rd) begin
            st_next.rvalid = 1'b1;
            case (bus.addr)
                LOW_FREQ_MODE_CONFIG_OFF:     st_next.rdata = st_reg.lf_cfg;
                SLEEP_CTRL_OFF:               st_next.rdata = st_reg.sleep_cfg;
                LINK_DETECT_STATE_OFF:
                    st_next.rdata = {7'h00, link_up};    // [RULE4] [RULE19]
                IO0_DIRECTION_CONFIG_OFF:     st_next.rdata = st_reg.io0_cfg;
                IO1_IO2_DIRECTION_CONFIG_OFF: st_next.rdata = st_reg.io12_cfg;
                IO3_OUT4_CONFIG_OFF:          st_next.rdata = st_reg.io3_cfg;
                OUT5_OUT6_CONFIG_OFF:         st_next.rdata = st_reg.o56_cfg;
                OUT7_OUT8_CONFIG_OFF:         st_next.rdata = st_reg.o78_cfg;
                COLOUR_DEPTH_CONFIG_OFF:      st_next.rdata = st_reg.depth_cfg;
                INTERRUPT_FORWARD_CTRL_OFF:   st_next.rdata = st_reg.fwd_cfg;
                PROTECTION_IRQ_STATUS_OFF:
                    st_next.rdata = {7'h00, st_reg.irq_pend};
                default:                      st_next.rdata = 8'h00;
            endcase
        end

        // pending irq: read clears, new fall wins over clear
        // a read of the status offset clears the flag, a remote
        // fall in the same cycle sets it again so no request is
        // lost, and turning forwarding off drops it outright
        // a remote pin held low raises no second request; only
        // a new fall does
        if (bus.rd && bus.addr == PROTECTION_IRQ_STATUS_OFF)
            st_next.irq_pend = 1'b0;                     // [RULE10]
        if (fwd_en && rirq_fall)
            st_next.irq_pend = 1'b1;                     // [RULE9]
        if (!fwd_en)
            st_next.irq_pend = 1'b0;
    end

    // ==========================================================
    // power-down pin synchroniser; no reset, so it settles
    // while rst is still high and adds no delay at release
    always_ff @(posedge clk_sys) begin
        pdn_sync <= {pdn_sync[0], power_down_n};
    end

    // block reset: rst or a synchronised low power-down pin
    assign blk_rst = rst | ~pdn_sync[1];

    // state register; the power-down reset restarts the
    // block so a new low-frequency range takes effect
    always_ff @(posedge clk_sys) begin
        if (blk_rst) begin                               // [RULE7]
            st_reg           <= '0;
            st_reg.lf_cfg    <= CFG_RESET;
            st_reg.depth_cfg <= CFG_RESET;
            st_reg.pclk_s    <= 2'b00;
            st_reg.rirq_s    <= 2'b11;
            st_reg.rirq_d    <= 1'b1;
            st_reg.fault_s   <= 2'b11;
            st_reg.pwr       <= SERSB_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    // data outputs come straight from the state struct;
    // direction and level outputs decode the config bytes
    // and so change the cycle after the write
    // the range output also follows the synchronised pin,
    // so either source selects the low range
    assign rdata             = st_reg.rdata;
    assign rvalid            = st_reg.rvalid;
    assign latch_edge_rising = st_reg.lf_cfg[LATCH_EDGE_BIT];   // [RULE5]
    assign low_freq_active   = (st_reg.lf_cfg[1:0] != 2'b00)
                             | st_reg.pin_lf_s[1];              // [RULE6]
    assign sleep_active      = (st_reg.pwr == SERSB_SLEEP);
    assign irq_out_n         = ~st_reg.irq_pend;                // [RULE9]
    assign gpio_out          = st_reg.bc_hold & is_out;         // [RULE18]
    assign gpio_oe_n         = ~is_out;
    assign fc_gpio_out       = st_reg.fc_hold;
    assign reg_driven_output = out_lvl;                         // [RULE17]
endmodule // sersb_top
`default_nettype wire

// ---- sim/sersb_partner.sv ----
// partner model: far-end pixel clock, remote irq and back-channel io
`default_nettype none
module sersb_partner
    import sersb_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  clk_run,
    input  wire logic                  irq_hold,
    input  wire logic [GPIO_COUNT-1:0] ser_out_mask,
    input  wire logic [GPIO_COUNT-1:0] io_value,
    output var  logic                  pclk_in,
    output var  logic                  remote_irq_in_n,
    output var  logic [GPIO_COUNT-1:0] bc_gpio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // clock stands still when stopped; unused io lines show inverse
    initial begin
        pclk_in = 1'b0;
        remote_irq_in_n = 1'b1;
        bc_gpio_in = 4'h0;
    end
    always @(negedge clk_sys) begin
        if (clk_run) pclk_in <= !pclk_in;
        remote_irq_in_n <= !irq_hold;
        bc_gpio_in <= (io_value & ser_out_mask)
            | (~io_value & ~ser_out_mask);
    end
endmodule // sersb_partner
`default_nettype wire

// ---- sim/sersb_checker.sv ----
// checker: port timing relations of the sideband block
`default_nettype none
module sersb_checker
    import sersb_pkg::*;
#(
    parameter int LOSS_CYCLES = CLK_LOSS_CYCLES
) (
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  power_down_n,
    input wire sersb_bus_type         bus,
    input wire logic [7:0]            rdata,
    input wire logic                  pclk_in,
    input wire logic                  cable_fault,
    input wire logic                  remote_irq_in_n,
    input wire logic [GPIO_COUNT-1:0] gpio_oe_n,
    input wire logic [OUT_COUNT-1:0]  reg_driven_output,
    input wire logic                  latch_edge_rising,
    input wire logic                  mode_18bit,
    input wire logic                  sleep_active,
    input wire logic                  irq_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle_cnt;
    logic       pclk_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !power_down_n);
    // ==========================================================
    // cycles since the last pixel clock change, saturating
    always_ff @(posedge clk_sys) begin
        pclk_q <= pclk_in;
        if (pclk_in != pclk_q) idle_cnt <= 8'h00;
        else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
    end
    AST_LINK: assert property (
        $stable(cable_fault) [*4] ##0 (bus.rd
        && bus.addr == LINK_DETECT_STATE_OFF)
        |=> rdata[0] != $past(cable_fault))
        else $error("link status wrong");
    AST_EDGE: assert property (
        bus.wr && bus.addr == LOW_FREQ_MODE_CONFIG_OFF
        |=> latch_edge_rising == $past(bus.wdata[LATCH_EDGE_BIT]))
        else $error("edge select wrong");
    AST_IRQ_SET: assert property (
        $fell(irq_out_n) |-> !$past(remote_irq_in_n, 2))
        else $error("irq without remote low");
    AST_IRQ_CLR: assert property (
        remote_irq_in_n [*6] ##0 (bus.rd
        && bus.addr == PROTECTION_IRQ_STATUS_OFF) |=> irq_out_n)
        else $error("irq not cleared by read");
    AST_MODE: assert property (
        bus.wr && bus.addr == COLOUR_DEPTH_CONFIG_OFF
        |=> mode_18bit == ($past(bus.wdata) == MODE_18BIT_CODE))
        else $error("colour mode wrong");
    AST_IO_DIR: assert property (
        bus.wr && bus.addr == IO3_OUT4_CONFIG_OFF && mode_18bit
        |=> gpio_oe_n[3] == ($past(bus.wdata[3:0]) != IO_OUTPUT_CODE))
        else $error("io direction wrong");
    AST_OUT: assert property (
        bus.wr && bus.addr == OUT7_OUT8_CONFIG_OFF && mode_18bit
        |=> reg_driven_output[4] == ($past(bus.wdata[7:4]) == OUT_HIGH_CODE))
        else $error("output level wrong");
    AST_SLEEP: assert property (
        $rose(sleep_active) |-> idle_cnt >= LOSS_CYCLES)
        else $error("sleep too early");
    AST_WAKE: assert property (
        sleep_active && $changed(pclk_in) |-> ##[1:8] !sleep_active)
        else $error("no wake on clock");
    COV_IRQ: cover property ($fell(irq_out_n));
    COV_SLEEP: cover property ($rose(sleep_active));
    COV_WAKE: cover property ($fell(sleep_active));
endmodule // sersb_checker
`default_nettype wire

// ---- sim/sersb_top_tb_top.sv ----
// testbench: registers, io paths, link status, irq and clock loss
`default_nettype none
module sersb_top_tb_top
    import sersb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, power_down_n, pclk_in, cable_fault, rvalid;
    logic low_freq_range_select, remote_irq_in_n, latch_edge_rising;
    logic low_freq_active, mode_18bit, sleep_active, irq_out_n;
    logic clk_run, irq_hold;
    logic [7:0] rdata, d;
    logic [3:0] colour_low_in, bc_gpio_in, fc_gpio_out, gpio_out;
    logic [3:0] gpio_oe_n, io_value;
    logic [4:0] reg_driven_output;
    logic [11:0] obs;
    logic [27:0] rows [9];
    sersb_bus_type bus;
    int fail_count, tests_run, i;
    assign obs = {mode_18bit, low_freq_active, latch_edge_rising,
                  gpio_oe_n, reg_driven_output};
    sersb_top #(.LOSS_CYCLES(8), .BIT_CYCLES(2)) dut (.clk_sys, .rst,
        .power_down_n, .bus, .rdata, .rvalid, .pclk_in, .cable_fault,
        .low_freq_range_select, .remote_irq_in_n, .colour_low_in,
        .bc_gpio_in, .fc_gpio_out, .gpio_out, .gpio_oe_n,
        .reg_driven_output, .latch_edge_rising, .low_freq_active,
        .mode_18bit, .sleep_active, .irq_out_n);
    sersb_partner far (.clk_sys, .clk_run, .irq_hold,
        .ser_out_mask(~gpio_oe_n), .io_value, .pclk_in,
        .remote_irq_in_n, .bc_gpio_in);
    // ==========================================================
    // compare, bus cycles, bounded wait and verdict
    task automatic check(input string n, input logic [11:0] e, g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, dat);
        @(negedge clk_sys);
        bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
        @(negedge clk_sys);
        bus.wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        bus.rd = 1'b0;
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int n);
        for (int k = 0; k < n && s !== v; k++) @(negedge clk_sys);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end
    initial begin
        #20us;
        fail_count++;
        complete_run;
    end
    // ==========================================================
    // main sequence
    initial begin
        rows = '{28'h040_43e0, 28'h120_4be0, 28'h040_1de0, 28'h0f9_5ce1,
                 28'h0e5_5c21, 28'h0d9_5c01, 28'h109_1c05, 28'h111_9c0d,
                 28'h0f1_3d0c};
        {rst, power_down_n, clk_run, cable_fault, irq_hold} = 5'h1c;
        {low_freq_range_select, colour_low_in, io_value} = 9'h0a5;
        bus = '0;
        fail_count = 0;
        tests_run = 0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        check("reset cfg", 12'h1e0, obs & 12'hdff);
        check("reset irq", 12'h002, {10'h000, irq_out_n, sleep_active});
        $display("test done: reset");
        for (i = 0; i < 9; i++) begin
            wr(rows[i][27:20], rows[i][19:12]);
            check("table", rows[i][11:0], obs);
        end
        rd(COLOUR_DEPTH_CONFIG_OFF);
        check("depth", 12'h004, {4'h0, d});
        rd(8'h33);
        check("unmapped", 12'h000, {4'h0, d});
        repeat (12) @(negedge clk_sys);
        check("gpio", 12'h085, {4'h0, fc_gpio_out, gpio_out});
        $display("test done: registers and io");
        cable_fault = 1'b1;
        repeat (4) @(negedge clk_sys);
        wr(LINK_DETECT_STATE_OFF, 8'h01);
        rd(LINK_DETECT_STATE_OFF);
        check("fault", 12'h000, {11'h000, d[0]});
        cable_fault = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(LINK_DETECT_STATE_OFF);
        check("link", 12'h001, {11'h000, d[0]});
        $display("test done: link");
        wr(INTERRUPT_FORWARD_CTRL_OFF, 8'h01);
        irq_hold = 1'b1;
        repeat (8) @(negedge clk_sys);
        check("masked", 12'h001, {11'h000, irq_out_n});
        irq_hold = 1'b0;
        wr(INTERRUPT_FORWARD_CTRL_OFF, 8'h21);
        for (i = 0; i < 2; i++) begin
            irq_hold = 1'b1;
            wait_for(irq_out_n, 1'b0, 10);
            check("irq", 12'h000, {11'h000, irq_out_n});
            irq_hold = 1'b0;
            repeat (7) @(negedge clk_sys);
            rd(PROTECTION_IRQ_STATUS_OFF);
            check("clear", 12'h003, {3'h0, d, irq_out_n});
        end
        $display("test done: irq");
        wr(SLEEP_CTRL_OFF, 8'h01);
        clk_run = 1'b0;
        wait_for(sleep_active, 1'b1, 30);
        check("sleep", 12'h003, {10'h000, sleep_active, mode_18bit});
        clk_run = 1'b1;
        wait_for(sleep_active, 1'b0, 10);
        rd(COLOUR_DEPTH_CONFIG_OFF);
        check("wake", 12'h008, {3'h0, d, sleep_active});
        $display("test done: clock loss");
        low_freq_range_select = 1'b1;
        wr(LOW_FREQ_MODE_CONFIG_OFF, 8'h00);
        repeat (3) @(negedge clk_sys);
        check("pin", 12'h001, {11'h000, low_freq_active});
        {power_down_n, low_freq_range_select} = 2'h0;
        repeat (3) @(negedge clk_sys);
        power_down_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("pdb", 12'h1e0, obs & 12'hdff);
        $display("test done: power down");
        complete_run;
    end
endmodule // sersb_top_tb_top
bind sersb_top sersb_checker #(.LOSS_CYCLES(LOSS_CYCLES)) chk (.clk_sys,
    .rst, .power_down_n, .bus, .rdata, .pclk_in, .cable_fault,
    .remote_irq_in_n, .gpio_oe_n, .reg_driven_output, .latch_edge_rising,
    .mode_18bit, .sleep_active, .irq_out_n);
`default_nettype wire
